// ---- psf_pkg.sv ----
// Package for the processor status flags block: field positions, offsets, types.
package psf_pkg;
	// Flag bit positions within the flags word
	localparam int unsigned FLG_CARRY = 0;
	localparam int unsigned FLG_ONE = 1;
	localparam int unsigned FLG_PARITY = 2;
	localparam int unsigned FLG_NIBBLE = 4;
	localparam int unsigned FLG_ZERO = 6;
	localparam int unsigned FLG_SIGN = 7;
	localparam int unsigned FLG_TRAP = 8;
	localparam int unsigned FLG_IRQ_EN = 9;
	localparam int unsigned FLG_DIR = 10;
	localparam int unsigned FLG_OVF = 11;
	localparam int unsigned FLG_IO_PRIVILEGE_FIELD_LO = 12;
	localparam int unsigned FLG_IO_PRIVILEGE_FIELD_HI = 13;
	localparam int unsigned FLG_NEST = 14;
	localparam int unsigned FLG_RESUME = 16;
	localparam int unsigned FLG_VLM = 17;
	localparam int unsigned FLG_ALIGN = 18;
	localparam int unsigned FLG_IDENT = 21;
	// Writable bits, forced-one bits and reset value of the flags word
	localparam logic [31:0] FLAGS_WMASK = 32'h0027_7fd5;
	localparam logic [31:0] FLAGS_ONES = 32'h0000_0002;
	localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
	// Control bit positions
	localparam int unsigned CFG4_IDENT_EN = 7;
	localparam int unsigned SYS0_ALIGN_MASK = 18;
	localparam int unsigned CTL_PROT = 0;
	// Register byte offsets
	localparam logic [7:0] OFS_FLAGS = 8'h00;
	localparam logic [7:0] OFS_CFG4 = 8'h04;
	localparam logic [7:0] OFS_SYS0 = 8'h08;
	localparam logic [7:0] OFS_CTL = 8'h0c;
	localparam logic [7:0] OFS_ALU_A = 8'h10;
	localparam logic [7:0] OFS_ALU_B = 8'h14;
	localparam logic [7:0] OFS_ALU_OP = 8'h18;
	localparam logic [7:0] OFS_EVT = 8'h1c;
	localparam logic [7:0] OFS_POP = 8'h20;
	localparam logic [7:0] OFS_CHECK = 8'h24;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
	// Event command bits written to the event register
	localparam int unsigned EVT_INTERRUPT_RETURN = 0;
	localparam int unsigned EVT_TASK_SW = 1;
	localparam int unsigned EVT_STEP_DONE = 2;
	localparam int unsigned EVT_BOUNDARY = 3;
	// Sticky interrupt status bits
	localparam int unsigned IRQ_STEP = 0;
	localparam int unsigned IRQ_ALIGN = 1;
	localparam int unsigned IRQ_GP13 = 2;
	localparam int unsigned IRQ_NUM = 3;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Arithmetic operations
	typedef enum logic [1:0] {
		PSF_OP_ADD,
		PSF_OP_SUB,
		PSF_OP_LOGIC
	} psf_op_e;

	// Operand width select: byte, word, dword
	typedef enum logic [1:0] {
		PSF_W8,
		PSF_W16,
		PSF_W32
	} psf_width_e;

	// Decision outputs toward the execution core
	typedef struct packed {
		logic irq_accept;
		logic align_fault;
		logic io_direct;
		logic priv_gp13;
		logic debug_suppress;
		logic string_decrement;
		logic nested_task;
		logic legacy_segments;
	} psf_ctl_s;
endpackage

// ---- psf_flags.sv ----
// Processor status flags word with ALU flag logic and an AXI4-Lite register slave.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module psf_flags (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Core-side inputs and decisions
	input wire logic maskable_irq_input,
	output psf_pkg::psf_ctl_s ctl,
	output logic irq
);
	import psf_pkg::*;

	// Register state
	logic [31:0] flags_q;
	logic [7:0] cfg4_q;
	logic [31:0] sys0_q;
	logic [3:0] ctl_q;
	logic [31:0] alu_a_q;
	logic [31:0] alu_b_q;
	logic [31:0] check_q;
	logic [IRQ_NUM-1:0] stat_q;
	logic [IRQ_NUM-1:0] mask_q;
	logic [2:0] irq_sync_q;
	logic resume_armed_q;
	psf_ctl_s ctl_q2;
	logic irq_q;

	// Write channel capture
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_fire;
	logic [31:0] wr_val;
	logic [31:0] cfg4_wr;
	logic resp_pending;

	// Control and check register fields
	logic prot_mode;
	logic [1:0] cur_priv;
	logic check_misaligned;
	logic check_privop;

	// Byte-lane merge of a register value with the write data
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Flags from an ALU operation at the given width
	function automatic logic [31:0] alu_flags(input logic [31:0] f, input logic [31:0] a,
			input logic [31:0] b, input psf_op_e op, input psf_width_e w);
		logic [32:0] full;
		logic [31:0] bb;
		logic [4:0] nib;
		logic [31:0] res;
		logic [31:0] r;
		logic cin;
		logic cout;
		logic cmsb;
		int unsigned top;
		r = f;
		bb = (op == PSF_OP_SUB) ? ~b : b;
		cin = (op == PSF_OP_SUB);
		full = {1'b0, a} + {1'b0, bb} + {32'h0000_0000, cin};
		res = full[31:0];
		unique case (w)
			PSF_W8: top = 7;
			PSF_W16: top = 15;
			default: top = 31;
		endcase
		// Carry out of the top bit and carry into it
		cout = (top == 31) ? full[32] : (a[top] & bb[top]) | ((a[top] ^ bb[top]) & ~res[top]);
		cmsb = a[top] ^ bb[top] ^ res[top];
		nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
		if (op == PSF_OP_LOGIC) begin
			res = a & b;
			r[FLG_CARRY] = 1'b0;
			r[FLG_OVF] = 1'b0;
			r[FLG_NIBBLE] = 1'b0;
		end else begin
			r[FLG_CARRY] = (op == PSF_OP_SUB) ? ~cout : cout;
			r[FLG_OVF] = cout ^ cmsb;
			r[FLG_NIBBLE] = (op == PSF_OP_SUB) ? ~nib[4] : nib[4];
		end
		r[FLG_SIGN] = res[top];
		unique case (w)
			PSF_W8: r[FLG_ZERO] = (res[7:0] == 8'h00);
			PSF_W16: r[FLG_ZERO] = (res[15:0] == 16'h0000);
			default: r[FLG_ZERO] = (res == 32'h0000_0000);
		endcase
		r[FLG_PARITY] = ~(^res[7:0]);
		return r;
	endfunction

	// Flags word as seen by readers and the core
	function automatic logic [31:0] clean(input logic [31:0] f);
		return (f & FLAGS_WMASK) | FLAGS_ONES;
	endfunction

	// Control fields, check levels and the write strobe
	assign prot_mode = ctl_q[CTL_PROT];
	assign cur_priv = ctl_q[2:1];
	assign check_misaligned = check_q[0];
	assign check_privop = check_q[1];
	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

	// A response not yet taken holds off new addresses and data
	assign resp_pending = s_axi_bvalid && !s_axi_bready;

	// Write address and data accepted in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// Ready while the capture slot is free and no response waits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !resp_pending;
			s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !resp_pending;
		end
	end

	// Write response, error on an unmapped offset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr_q[1:0] != 2'b00 || aw_addr_q > OFS_IRQ_MASK) ?
					RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Zero-filled write value, and the byte-merged value of the 8-bit config register
	assign wr_val = merge(32'h0000_0000, w_data_q, w_strb_q);
	assign cfg4_wr = merge({24'h00_0000, cfg4_q}, w_data_q, w_strb_q);

	// Plain configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg4_q <= 8'h00;
			sys0_q <= 32'h0000_0000;
			ctl_q <= 4'h0;
			alu_a_q <= 32'h0000_0000;
			alu_b_q <= 32'h0000_0000;
			check_q <= 32'h0000_0000;
			mask_q <= '0;
		end else if (wr_fire) begin
			unique case (aw_addr_q)
				OFS_CFG4: cfg4_q <= cfg4_wr[7:0];
				OFS_SYS0: sys0_q <= merge(sys0_q, w_data_q, w_strb_q);
				OFS_CTL: ctl_q <= wr_val[3:0];
				OFS_ALU_A: alu_a_q <= merge(alu_a_q, w_data_q, w_strb_q);
				OFS_ALU_B: alu_b_q <= merge(alu_b_q, w_data_q, w_strb_q);
				OFS_CHECK: check_q <= wr_val;
				OFS_IRQ_MASK: mask_q <= wr_val[IRQ_NUM-1:0];
				default: ;
			endcase
		end
	end

	// Flags word: direct writes, popped values, ALU results and events
	always_ff @(posedge aclk) begin
		logic [31:0] nxt;
		nxt = flags_q;
		if (!aresetn) begin
			flags_q <= FLAGS_RESET;
			resume_armed_q <= 1'b0;
		end else begin
			if (wr_fire && aw_addr_q == OFS_FLAGS) begin
				nxt = merge(flags_q, w_data_q, w_strb_q);
				if (!cfg4_q[CFG4_IDENT_EN]) begin
					nxt[FLG_IDENT] = flags_q[FLG_IDENT];
				end
				nxt[FLG_VLM] = flags_q[FLG_VLM];
			end
			if (wr_fire && aw_addr_q == OFS_POP) begin
				nxt = merge(flags_q, w_data_q, w_strb_q);
				if (!cfg4_q[CFG4_IDENT_EN]) begin
					nxt[FLG_IDENT] = flags_q[FLG_IDENT];
				end
				if (prot_mode && cur_priv > flags_q[FLG_IO_PRIVILEGE_FIELD_HI:FLG_IO_PRIVILEGE_FIELD_LO]) begin
					nxt[FLG_IRQ_EN] = flags_q[FLG_IRQ_EN];
				end
				nxt[FLG_VLM] = flags_q[FLG_VLM];
			end
			if (wr_fire && aw_addr_q == OFS_ALU_OP) begin
				nxt = alu_flags(flags_q, alu_a_q, alu_b_q, psf_op_e'(wr_val[1:0]),
						psf_width_e'(wr_val[3:2]));
			end
			// Events from the core: return, task switch, step done, boundary
			if (wr_fire && aw_addr_q == OFS_EVT) begin
				if ((wr_val[EVT_INTERRUPT_RETURN] && cur_priv == 2'b00) || wr_val[EVT_TASK_SW]) begin
					nxt[FLG_VLM] = wr_val[8 + FLG_VLM - 16];
				end
				if (wr_val[EVT_STEP_DONE] && flags_q[FLG_TRAP]) begin
					nxt[FLG_TRAP] = 1'b0;
				end
				if (wr_val[EVT_BOUNDARY]) begin
					resume_armed_q <= flags_q[FLG_RESUME];
					nxt[FLG_RESUME] = 1'b0;
				end
			end
			flags_q <= clean(nxt);
		end
	end

	// Sticky status: set wins over write-one-to-clear
	// Check bits are levels, so a clear only sticks once software drops them
	always_ff @(posedge aclk) begin
		logic [IRQ_NUM-1:0] setv;
		logic [IRQ_NUM-1:0] clr;
		setv = '0;
		clr = '0;
		if (!aresetn) begin
			stat_q <= '0;
		end else begin
			setv[IRQ_STEP] = wr_fire && aw_addr_q == OFS_EVT && wr_val[EVT_STEP_DONE] &&
					flags_q[FLG_TRAP];
			setv[IRQ_ALIGN] = ctl_q2.align_fault && check_misaligned;
			setv[IRQ_GP13] = ctl_q2.priv_gp13;
			if (wr_fire && aw_addr_q == OFS_IRQ_STAT) begin
				clr = wr_val[IRQ_NUM-1:0];
			end
			stat_q <= (stat_q & ~clr) | setv;
		end
	end

	// Interrupt input synchroniser, a rise counts once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_sync_q <= 3'b000;
		end else begin
			irq_sync_q <= {irq_sync_q[1:0], maskable_irq_input};
		end
	end

	// Registered decisions toward the core
	always_ff @(posedge aclk) begin
		logic [1:0] io_privilege_field;
		io_privilege_field = flags_q[FLG_IO_PRIVILEGE_FIELD_HI:FLG_IO_PRIVILEGE_FIELD_LO];
		if (!aresetn) begin
			ctl_q2 <= '0;
			irq_q <= 1'b0;
		end else begin
			ctl_q2.irq_accept <= (irq_sync_q[2] & irq_sync_q[1]) && flags_q[FLG_IRQ_EN];
			ctl_q2.align_fault <= flags_q[FLG_ALIGN] && sys0_q[SYS0_ALIGN_MASK];
			ctl_q2.io_direct <= !prot_mode || (!flags_q[FLG_VLM] && cur_priv <= io_privilege_field);
			ctl_q2.priv_gp13 <= prot_mode && flags_q[FLG_VLM] && check_privop;
			ctl_q2.legacy_segments <= prot_mode && flags_q[FLG_VLM];
			ctl_q2.debug_suppress <= resume_armed_q;
			ctl_q2.string_decrement <= flags_q[FLG_DIR];
			ctl_q2.nested_task <= prot_mode && flags_q[FLG_NEST];
			irq_q <= |(stat_q & mask_q);
		end
	end

	// Outputs straight from their flip-flops
	assign ctl = ctl_q2;
	assign irq = irq_q;

	// Read channel, one outstanding read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				unique case (s_axi_araddr)
					OFS_FLAGS: s_axi_rdata <= flags_q;
					OFS_POP: s_axi_rdata <= flags_q;
					OFS_CFG4: s_axi_rdata <= {24'h00_0000, cfg4_q};
					OFS_SYS0: s_axi_rdata <= sys0_q;
					OFS_CTL: s_axi_rdata <= {28'h000_0000, ctl_q};
					OFS_ALU_A: s_axi_rdata <= alu_a_q;
					OFS_ALU_B: s_axi_rdata <= alu_b_q;
					OFS_ALU_OP: s_axi_rdata <= 32'h0000_0000;
					OFS_EVT: s_axi_rdata <= {24'h00_0000, ctl_q2};
					OFS_CHECK: s_axi_rdata <= check_q;
					OFS_IRQ_STAT: s_axi_rdata <= {29'h0000_0000, stat_q};
					OFS_IRQ_MASK: s_axi_rdata <= {29'h0000_0000, mask_q};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// ---- psf_flags_properties.sv ----
// Checker with concurrent assertions on the processor status flags ports.
`timescale 1ns/1ps
module psf_props (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write side
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read side
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Core side
	input wire logic maskable_irq_input,
	input wire psf_pkg::psf_ctl_s ctl
);
	import psf_pkg::*;
	// All checks share the bus clock and reset
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Response channels hold until taken
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response changed before it was taken");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before it was taken");
	// Answers come in bounded time
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid) else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read data late");
	// New requests refused while a response is pending
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	// Error reads return zero
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
		else $error("error read returned data");
	// Legacy mode forbids direct port access
	a_legacy_io: assert property (ctl.legacy_segments |-> !ctl.io_direct)
		else $error("direct port access in legacy mode");
	// Quiet interrupt line never accepted
	a_irq_gate: assert property (!maskable_irq_input [*6] |-> !ctl.irq_accept)
		else $error("interrupt accepted with input low");
endmodule

bind psf_flags psf_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.maskable_irq_input(maskable_irq_input), .ctl(ctl));

// ---- test_processor_status_flags.sv ----
// Self-checking bench for the processor status flags block.
`timescale 1ns/1ps
module test_processor_status_flags;
	import psf_pkg::*;
	// Clock, reset and bench-driven inputs
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic maskable_irq_input = 1'b0;
	// Design outputs
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	psf_ctl_s ctl;
	logic [8:0] obs;
	int num_errors = 0;
	int cmp_count = 0;

	// Device under test
	psf_flags dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .maskable_irq_input(maskable_irq_input), .ctl(ctl), .irq(irq));

	// Observed levels: irq above the decision struct
	assign obs = {irq, ctl};

	// Clock at 40 MHz
	initial begin
		forever #12.5 aclk = ~aclk;
	end

	// Verdict and end of run
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Word compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Bus write: address and data offered together, bready held until response
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		if (n >= 50) begin
			num_errors++;
			end_of_test();
		end
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask

	// Bus read
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		d = s_axi_rdata;
		r = s_axi_rresp;
		if (n >= 50) begin
			num_errors++;
			end_of_test();
		end
	endtask

	// Read and compare data and response
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, er});
	endtask

	// Wait a few cycles for a level, then compare it
	task automatic see(input int i, input logic e);
		int n;
		n = 0;
		while (obs[i] !== e && n < 10) begin
			@(posedge aclk);
			n++;
		end
		chk({31'h0, obs[i]}, {31'h0, e});
	endtask

	// One arithmetic case: operands, opcode, flags under mask
	task automatic alu(input logic [31:0] a, input logic [31:0] b, input logic [3:0] op,
		input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		wr(OFS_ALU_A, a);
		wr(OFS_ALU_B, b);
		wr(OFS_ALU_OP, {28'h000_0000, op});
		rd(OFS_FLAGS, d, r);
		chk(d & m, e);
	endtask

	// Reset value and unmapped offsets
	task automatic t_reset();
		rc(OFS_FLAGS, FLAGS_RESET);
		rc(8'h30, 32'h0000_0000, RESP_SLVERR);
		wr(8'h30, 32'hffff_ffff, RESP_SLVERR);
		$display("test reset done");
	endtask

	// Writable bits, identify gate, reserved bits
	task automatic t_bits();
		wr(OFS_FLAGS, 32'hffff_ffff);
		rc(OFS_FLAGS, 32'h0005_7fd7);
		wr(OFS_CFG4, 32'h0000_0080);
		wr(OFS_FLAGS, 32'hffff_ffff);
		rc(OFS_FLAGS, 32'h0025_7fd7);
		wr(OFS_FLAGS, 32'h0000_0000);
		rc(OFS_FLAGS, FLAGS_RESET);
		$display("test bits done");
	endtask

	// Arithmetic flags at width boundaries
	task automatic t_alu();
		alu(32'hffff_ffff, 32'h0000_0001, 4'h8, 32'h0000_08d5, 32'h0000_0055);
		alu(32'h0000_007f, 32'h0000_0001, 4'h0, 32'h0000_08d5, 32'h0000_0890);
		alu(32'h0000_0000, 32'h0000_0001, 4'h5, 32'h0000_08d5, 32'h0000_0095);
		alu(32'h8000_0000, 32'h0000_0001, 4'h9, 32'h0000_08d5, 32'h0000_0814);
		alu(32'h0000_00f0, 32'h0000_0f0f, 4'ha, 32'h0000_00c4, 32'h0000_0044);
		$display("test alu done");
	endtask

	// Single step, sticky status, mask and interrupt line
	task automatic t_step();
		wr(OFS_FLAGS, 32'h0000_0102);
		wr(OFS_EVT, 32'h0000_0004);
		rc(OFS_FLAGS, FLAGS_RESET);
		rc(OFS_IRQ_STAT, 32'h0000_0001);
		see(8, 1'b0);
		wr(OFS_IRQ_MASK, 32'h0000_0001);
		see(8, 1'b1);
		wr(OFS_IRQ_STAT, 32'h0000_0001);
		see(8, 1'b0);
		wr(OFS_EVT, 32'h0000_0004);
		rc(OFS_IRQ_STAT, 32'h0000_0000);
		$display("test step done");
	endtask

	// Direction, nesting, port privilege, pop and interrupt gate
	task automatic t_ctrl();
		wr(OFS_FLAGS, 32'h0000_0400);
		see(2, 1'b1);
		wr(OFS_FLAGS, 32'h0000_0000);
		see(2, 1'b0);
		wr(OFS_CTL, 32'h0000_0001);
		wr(OFS_FLAGS, 32'h0000_4000);
		see(1, 1'b1);
		wr(OFS_CTL, 32'h0000_0007);
		see(5, 1'b0);
		wr(OFS_FLAGS, 32'h0000_3000);
		see(5, 1'b1);
		wr(OFS_FLAGS, 32'h0000_0000);
		wr(OFS_POP, 32'h0000_0200);
		rc(OFS_FLAGS, FLAGS_RESET);
		wr(OFS_CTL, 32'h0000_0001);
		wr(OFS_POP, 32'h0000_0200);
		rc(OFS_FLAGS, 32'h0000_0202);
		maskable_irq_input <= 1'b1;
		see(7, 1'b1);
		wr(OFS_FLAGS, 32'h0000_0000);
		repeat (8) @(posedge aclk);
		see(7, 1'b0);
		maskable_irq_input <= 1'b0;
		$display("test ctrl done");
	endtask

	// Alignment, legacy mode and resume flag
	task automatic t_vm();
		wr(OFS_FLAGS, 32'h0004_0000);
		wr(OFS_CHECK, 32'h0000_0001);
		see(6, 1'b0);
		rc(OFS_IRQ_STAT, 32'h0000_0000);
		wr(OFS_SYS0, 32'h0004_0000);
		see(6, 1'b1);
		wr(OFS_CHECK, 32'h0000_0001);
		rc(OFS_IRQ_STAT, 32'h0000_0002);
		wr(OFS_CHECK, 32'h0000_0000);
		wr(OFS_IRQ_STAT, 32'h0000_0002);
		rc(OFS_IRQ_STAT, 32'h0000_0000);
		wr(OFS_CTL, 32'h0000_0007);
		wr(OFS_EVT, 32'h0000_0201);
		rc(OFS_FLAGS, 32'h0004_0002);
		wr(OFS_EVT, 32'h0000_0202);
		see(0, 1'b1);
		see(5, 1'b0);
		wr(OFS_CHECK, 32'h0000_0002);
		see(4, 1'b1);
		rc(OFS_IRQ_STAT, 32'h0000_0004);
		wr(OFS_CHECK, 32'h0000_0000);
		wr(OFS_IRQ_STAT, 32'h0000_0004);
		rc(OFS_IRQ_STAT, 32'h0000_0000);
		wr(OFS_CTL, 32'h0000_0001);
		wr(OFS_EVT, 32'h0000_0001);
		see(0, 1'b0);
		wr(OFS_FLAGS, 32'h0001_0000);
		wr(OFS_EVT, 32'h0000_0008);
		see(3, 1'b1);
		rc(OFS_FLAGS, FLAGS_RESET);
		wr(OFS_EVT, 32'h0000_0008);
		see(3, 1'b0);
		$display("test vm done");
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_bits();
		t_alu();
		t_step();
		t_ctrl();
		t_vm();
		end_of_test();
	end
endmodule
